// ===== inc/mds_pkg.sv
// Constants, types and register map of the motion debounce and auto-sleep block
package mds_pkg;
  // ---------------------------------------------
  // Register map
  // ---------------------------------------------
  localparam logic [7:0] ADDR_THRESH = 8'h17;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h18;
  localparam logic [7:0] ADDR_INACT = 8'h29;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int MODE_BIT = 7;
  localparam int THR_MSB = 6;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int BASE_TICK_US = 1250;
  localparam int BASE_TICK_CYCLES = BASE_TICK_US * CLK_MHZ;
  localparam int STEP_MS = 320;
  localparam int STEP_SLOW_MS = 640;
  localparam int PER_W = 10;
  localparam logic [PER_W-1:0] STEP_TICKS = PER_W'(STEP_MS * 1000 / BASE_TICK_US);
  localparam logic [PER_W-1:0] STEP_SLOW_TICKS = PER_W'(STEP_SLOW_MS * 1000 / BASE_TICK_US);
  // Sample period in base ticks, indexed by rate code
  localparam logic [7:0][PER_W-1:0] RATE_PERIOD = {10'h200, 10'h080, 10'h040, 10'h010,
                                                    10'h008, 10'h004, 10'h002, 10'h001};
  localparam logic [PER_W-1:0] CAP_NORMAL = 10'h010;
  localparam logic [PER_W-1:0] CAP_LNLP = 10'h040;
  localparam logic [PER_W-1:0] CAP_HIRES = 10'h002;
  localparam logic [PER_W-1:0] CAP_LOWPWR = 10'h080;
  localparam logic [2:0] RATE_SLOWEST = 3'h7;
  localparam logic SLEEP_RATE_PREFIX = 1'b1;
  // ---------------------------------------------
  // Types
  // ---------------------------------------------
  typedef enum logic [1:0] {OS_NORMAL = 2'h0, OS_LNLP = 2'h1, OS_HIRES = 2'h2, OS_LOWPWR = 2'h3} mds_os_e;
  typedef enum logic [1:0] {ST_STANDBY = 2'h0, ST_WAKE = 2'h1, ST_SLEEP = 2'h2} mds_state_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mds_bus_s;
  typedef struct packed {
    logic [2:0] wakeRate;
    logic [1:0] sleepRate;
    logic activeMode;
    logic autoSleepEn;
    mds_os_e wakeOs;
    mds_os_e sleepOs;
    logic orSel;
    logic latchEn;
    logic [2:0] axisEn;
    logic intEnSleep;
    logic intEnOrient;
    logic intEnFfmt;
    logic wakeOrient;
    logic wakeFfmt;
  } mds_cfg_s;
  typedef struct packed {
    logic [7:0] z;
    logic [7:0] y;
    logic [7:0] x;
  } mds_axes_s;
endpackage

// ===== logic/mds_top.sv
// Freefall/motion debounce and auto wake/sleep controller
`timescale 1ns/1ps
module mds_top #(
  parameter int BASE_TICK_CYC = mds_pkg::BASE_TICK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input mds_pkg::mds_bus_s regReq,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input mds_pkg::mds_cfg_s cfg,
  input mds_pkg::mds_axes_s accelMag,
  input wire logic orientEvent,
  input wire logic srcRead,
  output logic sampleTick,
  output logic eventActive,
  output logic [2:0] effRate,
  output mds_pkg::mds_state_e powerState,
  output logic sleepChangeIrq
);
  import mds_pkg::*;

  localparam int BASE_W = $clog2(BASE_TICK_CYC + 1);

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [PER_W-1:0] periodOf(input logic [2:0] rate, input mds_os_e os);
    logic [PER_W-1:0] cap;
    cap = CAP_NORMAL;
    unique case (os)
      OS_NORMAL: cap = CAP_NORMAL;
      OS_LNLP: cap = CAP_LNLP;
      OS_HIRES: cap = CAP_HIRES;
      OS_LOWPWR: cap = CAP_LOWPWR;
    endcase
    return (RATE_PERIOD[rate] < cap) ? RATE_PERIOD[rate] : cap;
  endfunction

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  logic [7:0] threshReg, next_threshReg;
  logic [7:0] limitReg, next_limitReg;
  logic [7:0] inactDur, next_inactDur;
  logic [7:0] next_regRdData;
  logic next_regRdValid;
  logic [6:0] thrValue;
  logic dbcMode;

  always_comb
  begin
    next_threshReg = threshReg;
    next_limitReg = limitReg;
    next_inactDur = inactDur;
    next_regRdData = RESET_BYTE;
    next_regRdValid = regReq.rd;
    if (regReq.wr)
    begin
      unique case (regReq.addr)
        ADDR_THRESH: next_threshReg = regReq.wdata;
        ADDR_DEBOUNCE: next_limitReg = regReq.wdata;
        ADDR_INACT: next_inactDur = regReq.wdata;
        default: ;
      endcase
    end
    if (regReq.rd)
    begin
      unique case (regReq.addr)
        ADDR_THRESH: next_regRdData = threshReg;
        ADDR_DEBOUNCE: next_regRdData = limitReg;
        ADDR_INACT: next_regRdData = inactDur;
        default: next_regRdData = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      threshReg <= RESET_BYTE;
      limitReg <= RESET_BYTE;
      inactDur <= RESET_BYTE;
      regRdData <= RESET_BYTE;
      regRdValid <= 1'b0;
    end
    else
    begin
      threshReg <= next_threshReg;
      limitReg <= next_limitReg;
      inactDur <= next_inactDur;
      regRdData <= next_regRdData;
      regRdValid <= next_regRdValid;
    end
  end

  assign thrValue = threshReg[THR_MSB:0];
  assign dbcMode = threshReg[MODE_BIT];

  // ---------------------------------------------
  // Sample pacing
  // ---------------------------------------------
  mds_state_e state, next_state;
  logic [BASE_W-1:0] baseCnt, next_baseCnt;
  logic [PER_W-1:0] sampCnt, next_sampCnt;
  logic [2:0] next_effRate;
  logic next_sampleTick;
  logic baseTick;
  logic [2:0] curRate;
  logic [PER_W-1:0] curPeriod;

  always_comb
  begin
    curRate = cfg.wakeRate;
    if (state == ST_SLEEP)
    begin
      curRate = {SLEEP_RATE_PREFIX, cfg.sleepRate};
    end
    curPeriod = periodOf(curRate, (state == ST_SLEEP) ? cfg.sleepOs : cfg.wakeOs);
    baseTick = (state != ST_STANDBY) && (baseCnt == BASE_W'(BASE_TICK_CYC - 1));
    next_baseCnt = baseTick ? '0 : BASE_W'(baseCnt + 1'b1);
    next_sampCnt = sampCnt;
    next_sampleTick = 1'b0;
    next_effRate = curRate;
    if (state == ST_STANDBY)
    begin
      next_baseCnt = '0;
      next_sampCnt = '0;
    end
    else if (baseTick)
    begin
      if (sampCnt >= PER_W'(curPeriod - 1'b1))
      begin
        next_sampCnt = '0;
        next_sampleTick = 1'b1;
      end
      else
      begin
        next_sampCnt = PER_W'(sampCnt + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      baseCnt <= '0;
      sampCnt <= '0;
      sampleTick <= 1'b0;
      effRate <= 3'h0;
    end
    else
    begin
      baseCnt <= next_baseCnt;
      sampCnt <= next_sampCnt;
      sampleTick <= next_sampleTick;
      effRate <= next_effRate;
    end
  end

  // ---------------------------------------------
  // Threshold compare and debounce
  // ---------------------------------------------
  logic [7:0] dbcCnt, next_dbcCnt;
  logic next_eventActive;
  logic ffmtEvent, next_ffmtEvent;
  logic [2:0] axisHigh;
  logic cond;
  logic clrDbc;

  always_comb
  begin
    // Magnitudes arrive on the 8 g scale, one count per 0.063 g
    axisHigh[0] = accelMag.x > {1'b0, thrValue};
    axisHigh[1] = accelMag.y > {1'b0, thrValue};
    axisHigh[2] = accelMag.z > {1'b0, thrValue};
    if (cfg.orSel)
    begin
      cond = |(axisHigh & cfg.axisEn);
    end
    else
    begin
      cond = (|cfg.axisEn) && ((axisHigh & cfg.axisEn) == 3'h0);
    end
    clrDbc = cfg.latchEn && srcRead;
    next_dbcCnt = dbcCnt;
    next_eventActive = eventActive;
    if (clrDbc)
    begin
      next_dbcCnt = RESET_BYTE;
      next_eventActive = 1'b0;
    end
    if (sampleTick)
    begin
      if (cond)
      begin
        if (dbcCnt < limitReg)
        begin
          next_dbcCnt = 8'(dbcCnt + 1'b1);
        end
        else
        begin
          next_dbcCnt = limitReg;
        end
        if (next_dbcCnt == limitReg)
        begin
          next_eventActive = 1'b1;
        end
      end
      else if (dbcMode)
      begin
        next_dbcCnt = RESET_BYTE;
        if (!cfg.latchEn)
        begin
          next_eventActive = 1'b0;
        end
      end
      else
      begin
        if (!clrDbc && (dbcCnt != RESET_BYTE))
        begin
          next_dbcCnt = 8'(dbcCnt - 1'b1);
        end
        if (!cfg.latchEn && (next_dbcCnt == RESET_BYTE))
        begin
          next_eventActive = 1'b0;
        end
      end
    end
    next_ffmtEvent = next_eventActive && !eventActive;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dbcCnt <= RESET_BYTE;
      eventActive <= 1'b0;
      ffmtEvent <= 1'b0;
    end
    else
    begin
      dbcCnt <= next_dbcCnt;
      eventActive <= next_eventActive;
      ffmtEvent <= next_ffmtEvent;
    end
  end

  // ---------------------------------------------
  // Inactivity timer and power state
  // ---------------------------------------------
  logic [PER_W-1:0] stepCnt, next_stepCnt;
  logic [7:0] durCnt, next_durCnt;
  logic next_sleepChangeIrq;
  logic wakeReq;
  logic activity;
  logic [PER_W-1:0] stepLen;

  always_comb
  begin
    wakeReq = (ffmtEvent && cfg.intEnFfmt && cfg.wakeFfmt) ||
              (orientEvent && cfg.intEnOrient && cfg.wakeOrient);
    activity = ffmtEvent || orientEvent;
    stepLen = (curRate == RATE_SLOWEST) ? STEP_SLOW_TICKS : STEP_TICKS;
    next_state = state;
    unique case (state)
      ST_STANDBY: if (cfg.activeMode) next_state = ST_WAKE;
      ST_WAKE:
      begin
        if (!cfg.activeMode) next_state = ST_STANDBY;
        else if (cfg.autoSleepEn && !activity && (durCnt >= inactDur)) next_state = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (!cfg.activeMode) next_state = ST_STANDBY;
        else if (!cfg.autoSleepEn || wakeReq) next_state = ST_WAKE;
      end
      default: next_state = ST_STANDBY;
    endcase
    next_stepCnt = stepCnt;
    next_durCnt = durCnt;
    if ((state != ST_WAKE) || (next_state != ST_WAKE) || activity)
    begin
      next_stepCnt = '0;
      next_durCnt = RESET_BYTE;
    end
    else if (baseTick)
    begin
      if (stepCnt >= PER_W'(stepLen - 1'b1))
      begin
        next_stepCnt = '0;
        if (durCnt != 8'hff) next_durCnt = 8'(durCnt + 1'b1);
      end
      else
      begin
        next_stepCnt = PER_W'(stepCnt + 1'b1);
      end
    end
    next_sleepChangeIrq = cfg.intEnSleep && (next_state != state) &&
                          ((next_state == ST_SLEEP) || (state == ST_SLEEP));
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= ST_STANDBY;
      stepCnt <= '0;
      durCnt <= RESET_BYTE;
      sleepChangeIrq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      stepCnt <= next_stepCnt;
      durCnt <= next_durCnt;
      sleepChangeIrq <= next_sleepChangeIrq;
    end
  end

  assign powerState = state;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_thresh_reset_zero: assert property ($past(rst) |-> (threshReg == 8'h00) && (limitReg == 8'h00))
    else $error("threshold or count not zero after reset");
  a_dbc_mode_clear: assert property (sampleTick && !cond && dbcMode |=> dbcCnt == 8'h00)
    else $error("debounce counter not cleared");
  a_dbc_step_down: assert property (sampleTick && !cond && !dbcMode && !clrDbc && dbcCnt != 8'h00
    |=> dbcCnt == 8'($past(dbcCnt) - 1'b1))
    else $error("debounce counter did not step down");
  a_dbc_saturate: assert property (sampleTick && cond && !clrDbc && dbcCnt == limitReg
    |=> dbcCnt == $past(limitReg))
    else $error("debounce counter passed limit");
  a_event_cause: assert property ($rose(eventActive) |-> $past(sampleTick && cond))
    else $error("event flag set without a matching sample");
  a_no_auto_sleep: assert property (!cfg.autoSleepEn |=> state != ST_SLEEP)
    else $error("sleep entered with auto-sleep off");
  a_sleep_irq_edge: assert property (cfg.intEnSleep && state == ST_WAKE && next_state == ST_SLEEP
    |=> sleepChangeIrq && state == ST_SLEEP ##1 !sleepChangeIrq)
    else $error("missing sleep change pulse");
  a_wake_cause: assert property (state == ST_SLEEP && cfg.activeMode && cfg.autoSleepEn ##1 state == ST_WAKE
    |-> $past(wakeReq))
    else $error("woke without a wake source");
  a_sleep_rate: assert property (state == ST_SLEEP |=> effRate == {SLEEP_RATE_PREFIX, $past(cfg.sleepRate)})
    else $error("sleep rate not applied");
  a_latch_clear: assert property (clrDbc && !sampleTick |=> !eventActive && dbcCnt == 8'h00)
    else $error("source read did not clear");

  c_event_fire: cover property ($rose(eventActive));
  c_enter_sleep: cover property (state == ST_WAKE ##1 state == ST_SLEEP);
  c_wake_up: cover property (state == ST_SLEEP ##1 state == ST_WAKE);
  c_latch_read: cover property (eventActive && clrDbc);
endmodule // mds_top

// ===== verification/mds_host_model.sv
// Host register master model driving the block's strobe register port
`timescale 1ns/1ps
module mds_host_model
(
  input wire logic sys_clk,
  output mds_pkg::mds_bus_s regReq,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  import mds_pkg::*;
  initial regReq = '0;
  // Released address and data show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge sys_clk);
    regReq <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
  endtask
  // Read data is taken one edge after the strobe is released
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    regReq <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hff};
    @(posedge sys_clk);
    d = regRdValid ? regRdData : 'x;
  endtask
endmodule // mds_host_model

// ===== verification/testbench.sv
// Self-checking bench for the motion debounce and auto-sleep block
`timescale 1ns/1ps
module testbench;
  import mds_pkg::*;
  localparam int TICK = 4;
  typedef struct packed {logic orSel; logic [2:0] axisEn; logic [6:0] thr; mds_axes_s mag; logic exp;} mds_row_s;
  localparam mds_row_s ROWS [8] = '{
    {1'h1, 3'h7, 7'h0a, 24'h00000b, 1'h1},
    {1'h1, 3'h7, 7'h0a, 24'h00000a, 1'h0},
    {1'h0, 3'h7, 7'h0a, 24'h0a0a0a, 1'h1},
    {1'h0, 3'h7, 7'h0a, 24'h0a0b0a, 1'h0},
    {1'h0, 3'h0, 7'h0a, 24'h000000, 1'h0},
    {1'h1, 3'h6, 7'h0a, 24'h0000ff, 1'h0},
    {1'h1, 3'h7, 7'h7f, 24'h0000ff, 1'h1},
    {1'h1, 3'h7, 7'h7f, 24'h00007f, 1'h0}};
  logic sys_clk;
  logic rst;
  logic orientEvent;
  logic srcRead;
  mds_bus_s regReq;
  logic [7:0] regRdData;
  logic regRdValid;
  mds_cfg_s cfg;
  mds_axes_s accelMag;
  logic sampleTick;
  logic eventActive;
  logic [2:0] effRate;
  mds_state_e powerState;
  logic sleepChangeIrq;
  int mismatches;
  int cmp_count;
  int cycles;
  int irqSeen;
  int n;
  logic [7:0] rd;

  mds_top #(.BASE_TICK_CYC(TICK)) mds_top_inst (.sys_clk(sys_clk), .rst(rst), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .cfg(cfg), .accelMag(accelMag),
    .orientEvent(orientEvent), .srcRead(srcRead), .sampleTick(sampleTick), .eventActive(eventActive),
    .effRate(effRate), .powerState(powerState), .sleepChangeIrq(sleepChangeIrq));
  mds_host_model mds_host_model_inst (.sys_clk(sys_clk), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid));

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (!ok)
    begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    mds_host_model_inst.rd(a, rd);
    check(rd === e, "register read value");
  endtask
  // Returns one edge after the n-th sample edge
  task automatic samp(input int k);
    repeat (k)
    begin
      @(posedge sys_clk);
      while (sampleTick !== 1'h1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
  endtask
  task automatic seq(input logic tr, input int k, input logic [7:0] pat);
    accelMag <= tr ? 24'h0000ff : 24'h000000;
    for (int i = 0; i < k; i++)
    begin
      samp(1);
      check(eventActive === pat[i], "event flag after sample");
    end
  endtask
  task automatic pulse_orient;
    orientEvent <= 1'h1;
    @(posedge sys_clk);
    orientEvent <= 1'h0;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------
  // Clock, timeout, interrupt monitor
  // ---------------------------------------------
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (sleepChangeIrq === 1'h1)
      irqSeen++;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial
  begin
    rst = 1'h1;
    cfg = '0;
    accelMag = '0;
    orientEvent = 1'h0;
    srcRead = 1'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    check(powerState === ST_STANDBY && eventActive === 1'h0, "reset outputs");
    rdchk(ADDR_THRESH, 8'h00);
    rdchk(ADDR_DEBOUNCE, 8'h00);
    rdchk(ADDR_INACT, 8'h00);
    mds_host_model_inst.wr(8'h20, 8'h5a);
    rdchk(8'h20, 8'h00);
    mds_host_model_inst.wr(ADDR_THRESH, 8'h8a);
    mds_host_model_inst.wr(ADDR_DEBOUNCE, 8'h05);
    mds_host_model_inst.wr(ADDR_INACT, 8'hff);
    rdchk(ADDR_THRESH, 8'h8a);
    rdchk(ADDR_DEBOUNCE, 8'h05);
    rdchk(ADDR_INACT, 8'hff);
    $display("test registers done");
    mds_host_model_inst.wr(ADDR_DEBOUNCE, 8'h00);
    mds_host_model_inst.wr(ADDR_INACT, 8'h00);
    cfg.activeMode <= 1'h1;
    foreach (ROWS[r])
    begin
      cfg.orSel <= ROWS[r].orSel;
      cfg.axisEn <= ROWS[r].axisEn;
      accelMag <= ROWS[r].mag;
      mds_host_model_inst.wr(ADDR_THRESH, {1'h1, ROWS[r].thr});
      samp(2);
      check(eventActive === ROWS[r].exp, "threshold compare row");
    end
    $display("test threshold table done");
    cfg.orSel <= 1'h1;
    cfg.axisEn <= 3'h7;
    accelMag <= 24'h000000;
    mds_host_model_inst.wr(ADDR_THRESH, 8'h0a);
    mds_host_model_inst.wr(ADDR_DEBOUNCE, 8'h03);
    seq(1'h1, 6, 8'h3c);
    seq(1'h0, 3, 8'h03);
    mds_host_model_inst.wr(ADDR_THRESH, 8'h8a);
    seq(1'h1, 2, 8'h00);
    seq(1'h0, 1, 8'h00);
    seq(1'h1, 3, 8'h04);
    seq(1'h0, 1, 8'h00);
    $display("test debounce done");
    cfg.latchEn <= 1'h1;
    mds_host_model_inst.wr(ADDR_DEBOUNCE, 8'h00);
    seq(1'h1, 1, 8'h01);
    seq(1'h0, 2, 8'h03);
    srcRead <= 1'h1;
    @(posedge sys_clk);
    srcRead <= 1'h0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    check(eventActive === 1'h0, "latched flag cleared by source read");
    cfg.latchEn <= 1'h0;
    cfg.wakeRate <= 3'h4;
    cfg.wakeOs <= OS_HIRES;
    samp(2);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (sampleTick !== 1'h1);
    check(n == 2 * TICK - 1, "sample spacing capped in high resolution");
    cfg.wakeRate <= 3'h0;
    cfg.wakeOs <= OS_NORMAL;
    check(powerState === ST_WAKE, "no sleep without auto-sleep");
    $display("test latch and rate done");
    cfg.intEnSleep <= 1'h1;
    cfg.autoSleepEn <= 1'h1;
    repeat (4) @(posedge sys_clk);
    check(powerState === ST_SLEEP && irqSeen == 1, "auto sleep with interrupt");
    for (int s = 0; s < 4; s++)
    begin
      cfg.sleepRate <= 2'(s);
      repeat (3) @(posedge sys_clk);
      check(effRate === {SLEEP_RATE_PREFIX, 2'(s)}, "sleep rate code");
    end
    mds_host_model_inst.wr(ADDR_INACT, 8'h01);
    pulse_orient();
    repeat (3) @(posedge sys_clk);
    check(powerState === ST_SLEEP, "orientation without enables ignored");
    cfg.intEnOrient <= 1'h1;
    cfg.wakeOrient <= 1'h1;
    @(posedge sys_clk);
    pulse_orient();
    repeat (3) @(posedge sys_clk);
    check(powerState === ST_WAKE && irqSeen == 2, "enabled orientation wakes");
    repeat (700) @(posedge sys_clk);
    pulse_orient();
    repeat (700) @(posedge sys_clk);
    check(powerState === ST_WAKE, "orientation restarts inactivity");
    repeat (500) @(posedge sys_clk);
    check(powerState === ST_SLEEP && irqSeen == 3, "sleep after inactivity");
    cfg.intEnFfmt <= 1'h1;
    cfg.wakeFfmt <= 1'h1;
    accelMag <= 24'h0000ff;
    samp(1);
    check(eventActive === 1'h1, "detection runs in sleep");
    repeat (3) @(posedge sys_clk);
    check(powerState === ST_WAKE && irqSeen == 4, "enabled motion wakes");
    cfg.activeMode <= 1'h0;
    repeat (3) @(posedge sys_clk);
    check(powerState === ST_STANDBY && irqSeen == 4, "standby when inactive");
    $display("test power states done");
    rst <= 1'h1;
    cfg.activeMode <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    check(powerState === ST_STANDBY && eventActive === 1'h0, "outputs after mid-run reset");
    rdchk(ADDR_THRESH, 8'h00);
    rdchk(ADDR_DEBOUNCE, 8'h00);
    rdchk(ADDR_INACT, 8'h00);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule // testbench
